// File: ci_decode_pkg.sv
// Package with field layout and register map of the custom instruction decoder
package ci_decode_pkg;

  // ****************************************************
  // Instruction word layout
  // ****************************************************
  localparam logic [5:0] CUSTOM_OPCODE = 6'h32;
  localparam int OPCODE_LSB = 0;
  localparam int OPCODE_W = 6;
  localparam int SEL_LSB = 6;
  localparam int SEL_W = 8;
  localparam int NUM_OPS = 256;
  localparam int WRC_BIT = 14;
  localparam int RDB_BIT = 15;
  localparam int RDA_BIT = 16;
  localparam int C_LSB = 17;
  localparam int B_LSB = 22;
  localparam int A_LSB = 27;
  localparam int REG_W = 5;

  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [11:0] INSTR_OFS = 12'h000;
  localparam logic [11:0] CTRL_OFS = 12'h004;
  localparam logic [11:0] STAT_OFS = 12'h008;
  localparam logic [11:0] OPS_OFS = 12'h00c;
  localparam logic [11:0] SEL_OFS = 12'h010;
  localparam logic [31:0] INSTR_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam int CTRL_MULTI_BIT = 0;
  localparam int CTRL_IREG_BIT = 1;
  localparam int CTRL_FIX_LSB = 8;
  localparam int STAT_VALID_BIT = 0;
  localparam int STAT_IREG_BIT = 1;
  localparam int STAT_ILLEGAL_BIT = 2;

  typedef struct packed {
    logic [4:0] addr_a;
    logic [4:0] addr_b;
    logic [4:0] addr_c;
    logic use_gpr_a;
    logic use_gpr_b;
    logic use_gpr_c;
    logic [7:0] sel_index;
  } ci_fields_t;

endpackage : ci_decode_pkg

// File: ci_decode_sva.sv
// Port assertions of the custom instruction decoder
`timescale 1ns/1ns
module ci_decode_sva
#(
  parameter int EXT_W = 8
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic issue_valid,
  input wire logic [31:0] issue_instr,
  input wire logic [31:0] unit_result,
  input wire logic unit_start,
  input wire logic [EXT_W-1:0] unit_func_sel,
  input wire logic readra,
  input wire logic readrb,
  input wire logic writerc,
  input wire logic [4:0] addr_a,
  input wire logic [4:0] addr_b,
  input wire logic [4:0] addr_c,
  input wire logic gpr_we,
  input wire logic creg_we,
  input wire logic [4:0] wr_addr,
  input wire logic [31:0] wr_data
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_issue_start;
    issue_valid ##1 unit_start;
  endsequence
  sequence s_write_back;
    gpr_we || creg_we;
  endsequence
  a_start_cause: assert property (unit_start |-> $past(issue_valid &&
    issue_instr[5:0] == 6'h32) || $past(psel && penable && pwrite &&
    paddr == 12'h000, 2))
    else $error("start without custom word");
  a_fields_copy: assert property (s_issue_start |->
    {addr_a, addr_b, addr_c} == $past(issue_instr[31:17]))
    else $error("operand addresses wrong");
  a_index_copy: assert property (s_issue_start |-> unit_func_sel ==
    $past(issue_instr[6 +: EXT_W]) && {readra, readrb, writerc} ==
    $past(issue_instr[16:14]))
    else $error("index or selectors wrong");
  a_we_select: assert property (unit_start |=> gpr_we == $past(writerc) &&
    creg_we == !$past(writerc))
    else $error("write enable choice wrong");
  a_we_cause: assert property (s_write_back |-> $past(unit_start))
    else $error("write without start");
  a_wr_data: assert property (s_write_back |-> wr_data == $past(unit_result)
    && wr_addr == $past(addr_c))
    else $error("write data or address wrong");
  a_fields_hold: assert property (!unit_start |-> $stable({addr_a, addr_b,
    addr_c, readra, readrb, writerc}))
    else $error("fields changed without start");
  a_ready_high: assert property (psel |-> pready)
    else $error("pready low");
endmodule : ci_decode_sva

bind custom_instr_word_decoder ci_decode_sva #(.EXT_W(EXT_W)) u_sva (.*);

// File: ci_field_extract.sv
// Field extraction of one instruction word
`timescale 1ns/1ns
module ci_field_extract
(
  input wire logic [31:0] instr,
  output logic is_custom,
  output ci_decode_pkg::ci_fields_t fields
);

  logic [ci_decode_pkg::OPCODE_W-1:0] opcode_field;

  assign opcode_field = instr[ci_decode_pkg::OPCODE_LSB +:
    ci_decode_pkg::OPCODE_W];
  assign is_custom = opcode_field == ci_decode_pkg::CUSTOM_OPCODE;

  // One driver for the whole field set
  always_comb
  begin
    fields.sel_index =
      instr[ci_decode_pkg::SEL_LSB +: ci_decode_pkg::SEL_W];
    fields.addr_a =
      instr[ci_decode_pkg::A_LSB +: ci_decode_pkg::REG_W];
    fields.addr_b =
      instr[ci_decode_pkg::B_LSB +: ci_decode_pkg::REG_W];
    fields.addr_c =
      instr[ci_decode_pkg::C_LSB +: ci_decode_pkg::REG_W];
    fields.use_gpr_a = instr[ci_decode_pkg::RDA_BIT];
    fields.use_gpr_b = instr[ci_decode_pkg::RDB_BIT];
    fields.use_gpr_c = instr[ci_decode_pkg::WRC_BIT];
  end

endmodule : ci_field_extract

// File: ci_unit_model.sv
// Behavioural custom unit with internal operands and result
`timescale 1ns/1ns
module ci_unit_model
#(
  parameter logic [31:0] CREG_A = 32'h0000_0000,
  parameter logic [31:0] CREG_B = 32'h0000_0000
)
(
  input wire logic unit_start,
  input wire logic [31:0] unit_dataa,
  input wire logic [31:0] unit_datab,
  output logic [31:0] creg_a_data,
  output logic [31:0] creg_b_data,
  output logic [31:0] unit_result
);
  assign creg_a_data = CREG_A;
  assign creg_b_data = CREG_B;
  // Result only valid while started
  assign unit_result = unit_start ? unit_dataa ^ unit_datab :
    ~(unit_dataa ^ unit_datab);
endmodule : ci_unit_model

// File: custom_instr_word_decoder.sv
// Custom instruction word decoder with APB register access
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ns
module custom_instr_word_decoder
#(
  parameter int EXT_W = 8,
  parameter logic [7:0] UNIT_INDEX = 8'h00
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic issue_valid,
  input wire logic [31:0] issue_instr,
  input wire logic [31:0] gpr_a_data,
  input wire logic [31:0] gpr_b_data,
  input wire logic [31:0] creg_a_data,
  input wire logic [31:0] creg_b_data,
  input wire logic [31:0] unit_result,
  output logic unit_start,
  output logic [EXT_W-1:0] unit_func_sel,
  output logic [31:0] unit_dataa,
  output logic [31:0] unit_datab,
  output logic readra,
  output logic readrb,
  output logic writerc,
  output logic [4:0] addr_a,
  output logic [4:0] addr_b,
  output logic [4:0] addr_c,
  output logic gpr_we,
  output logic creg_we,
  output logic [4:0] wr_addr,
  output logic [31:0] wr_data
);

  // ****************************************************
  // Registers and decode
  // ****************************************************
  logic [31:0] instr_ff;
  logic [31:0] ctrl_ff;
  logic valid_ff;
  logic ireg_used_ff;
  logic illegal_ff;
  logic sw_pulse_ff;
  logic [31:0] cur_instr;
  logic cur_valid;
  logic is_custom;
  logic index_hit;
  logic ireg_req;
  logic accept;
  logic apb_wr;
  logic [31:0] nxt_prdata;
  ci_decode_pkg::ci_fields_t fields;

  assign apb_wr = psel && penable && pwrite;
  assign cur_instr = issue_valid ? issue_instr : instr_ff;
  assign cur_valid = issue_valid || sw_pulse_ff;

  ci_field_extract u_extract
  (
    .instr(cur_instr),
    .is_custom(is_custom),
    .fields(fields)
  );

  // Multi-operation unit matches high index bits only
  always_comb
  begin
    if (ctrl_ff[ci_decode_pkg::CTRL_MULTI_BIT] && EXT_W < 8)
    begin
      index_hit = (fields.sel_index >> EXT_W) ==
        (UNIT_INDEX >> EXT_W);
    end
    else if (ctrl_ff[ci_decode_pkg::CTRL_MULTI_BIT])
    begin
      index_hit = 1'b1;
    end
    else
    begin
      index_hit = fields.sel_index ==
        ctrl_ff[ci_decode_pkg::CTRL_FIX_LSB +: 8];
    end
  end

  // Any selector at 0 needs an internal file
  assign ireg_req = !(fields.use_gpr_a && fields.use_gpr_b &&
    fields.use_gpr_c);
  assign accept = cur_valid && is_custom && index_hit &&
    (!ireg_req || ctrl_ff[ci_decode_pkg::CTRL_IREG_BIT]);

  // ****************************************************
  // APB slave
  // ****************************************************
  assign pready = 1'b1;
  always_comb
  begin
    pslverr = 1'b0;
    nxt_prdata = 32'h0000_0000;
    unique case (paddr)
      ci_decode_pkg::INSTR_OFS: nxt_prdata = instr_ff;
      ci_decode_pkg::CTRL_OFS: nxt_prdata = ctrl_ff;
      ci_decode_pkg::STAT_OFS:
      begin
        nxt_prdata[ci_decode_pkg::STAT_VALID_BIT] = valid_ff;
        nxt_prdata[ci_decode_pkg::STAT_IREG_BIT] = ireg_used_ff;
        nxt_prdata[ci_decode_pkg::STAT_ILLEGAL_BIT] = illegal_ff;
      end
      ci_decode_pkg::OPS_OFS:
        nxt_prdata = {17'h0_0000, addr_a, addr_b, addr_c};
      ci_decode_pkg::SEL_OFS:
        nxt_prdata = {24'h00_0000, 8'(fields.sel_index)};
      default: pslverr = psel && penable;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= nxt_prdata;
  end

  // Software write strobe
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sw_pulse_ff <= 1'b0;
    else
      sw_pulse_ff <= apb_wr && paddr == ci_decode_pkg::INSTR_OFS;
  end

  // Instruction word, issue beats software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      instr_ff <= ci_decode_pkg::INSTR_RST;
    else if (issue_valid)
      instr_ff <= issue_instr;
    else if (apb_wr && paddr == ci_decode_pkg::INSTR_OFS)
      instr_ff <= pwdata;
  end

  // Unit configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_ff <= ci_decode_pkg::CTRL_RST;
    else if (apb_wr && paddr == ci_decode_pkg::CTRL_OFS)
      ctrl_ff <= pwdata;
  end

  // ****************************************************
  // Issue to the custom unit
  // ****************************************************
  // Start pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      unit_start <= 1'b0;
    else
      unit_start <= accept;
  end

  // Status of the last word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      valid_ff <= 1'b0;
      illegal_ff <= 1'b0;
    end
    else if (cur_valid)
    begin
      valid_ff <= accept;
      illegal_ff <= is_custom && index_hit && !accept;
    end
  end

  // Function select and internal file use
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      unit_func_sel <= '0;
      ireg_used_ff <= 1'b0;
    end
    else if (accept)
    begin
      unit_func_sel <= fields.sel_index[EXT_W-1:0];
      ireg_used_ff <= ireg_req;
    end
  end

  // Register-file selectors
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      readra <= 1'b1;
      readrb <= 1'b1;
      writerc <= 1'b1;
    end
    else if (accept)
    begin
      readra <= fields.use_gpr_a;
      readrb <= fields.use_gpr_b;
      writerc <= fields.use_gpr_c;
    end
  end

  // Operand addresses
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      addr_a <= 5'h00;
      addr_b <= 5'h00;
      addr_c <= 5'h00;
    end
    else if (accept)
    begin
      addr_a <= fields.addr_a;
      addr_b <= fields.addr_b;
      addr_c <= fields.addr_c;
    end
  end

  // Operand data from the chosen file
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      unit_dataa <= 32'h0000_0000;
      unit_datab <= 32'h0000_0000;
    end
    else if (accept)
    begin
      unit_dataa <= fields.use_gpr_a ? gpr_a_data : creg_a_data;
      unit_datab <= fields.use_gpr_b ? gpr_b_data : creg_b_data;
    end
  end

  // ****************************************************
  // Result write-back
  // ****************************************************
  // Write enable into the chosen file
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gpr_we <= 1'b0;
      creg_we <= 1'b0;
    end
    else
    begin
      gpr_we <= unit_start && writerc;
      creg_we <= unit_start && !writerc;
    end
  end

  // Result and its destination
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_addr <= 5'h00;
      wr_data <= 32'h0000_0000;
    end
    else if (unit_start)
    begin
      wr_addr <= addr_c;
      wr_data <= unit_result;
    end
  end

endmodule : custom_instr_word_decoder

// File: testbench.sv
// Testbench of the custom instruction word decoder
`timescale 1ns/1ns
module testbench;
  localparam logic [31:0] GA = 32'h1111_0000;
  localparam logic [31:0] GB = 32'h0000_2222;
  localparam logic [31:0] CA = 32'ha000_0005;
  localparam logic [31:0] CB = 32'h0b00_0000;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic issue_valid, unit_start, readra, readrb, writerc, gpr_we, creg_we;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, issue_instr, creg_a_data, creg_b_data, rd;
  logic [31:0] unit_result, unit_dataa, unit_datab, wr_data;
  logic [7:0] unit_func_sel;
  logic [4:0] addr_a, addr_b, addr_c, wr_addr;
  int n_fail, check_count, cyc;
  custom_instr_word_decoder dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .issue_valid, .issue_instr,
    .gpr_a_data(GA), .gpr_b_data(GB), .creg_a_data, .creg_b_data,
    .unit_result, .unit_start, .unit_func_sel, .unit_dataa, .unit_datab,
    .readra, .readrb, .writerc, .addr_a, .addr_b, .addr_c, .gpr_we, .creg_we,
    .wr_addr, .wr_data);
  ci_unit_model #(.CREG_A(CA), .CREG_B(CB)) unit (.unit_start, .unit_dataa,
    .unit_datab, .creg_a_data, .creg_b_data, .unit_result);
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic check(input string what, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic [31:0] cw(input logic [7:0] n,
    input logic [4:0] c, a, b, input logic rc, ra, rb);
    return {a, b, c, ra, rb, rc, n, ci_decode_pkg::CUSTOM_OPCODE};
  endfunction : cw
  task automatic issue(input logic [31:0] w, input logic go);
    logic [31:0] a, b;
    a = w[16] ? GA : CA;
    b = w[15] ? GB : CB;
    @(posedge pclk);
    issue_valid <= 1'b1;
    issue_instr <= w;
    @(posedge pclk);
    issue_valid <= 1'b0;
    #1;
    check("start", unit_start, go);
    if (go)
    begin
      check("fields", {addr_a, addr_b, addr_c, readra, readrb, writerc,
        unit_func_sel}, w[31:6]);
      check("data a", unit_dataa, a);
      check("data b", unit_datab, b);
      @(posedge pclk);
      #1;
      check("we", {gpr_we, creg_we, wr_addr},
        {w[14], !w[14], w[21:17]});
      check("wdata", wr_data, a ^ b);
    end
  endtask : issue
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_fail++;
      give_verdict();
    end
  end
  initial
  begin
    {presetn, psel, penable, pwrite, issue_valid} = '0;
    paddr = '0;
    pwdata = '0;
    issue_instr = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    check("rst", {readra, readrb, writerc, unit_start}, 4'he);
    apb(1'b0, ci_decode_pkg::CTRL_OFS, 0);
    check("ctrl", rd, ci_decode_pkg::CTRL_RST);
    apb(1'b0, 12'h014, 0);
    check("unmapped", {err, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, ci_decode_pkg::CTRL_OFS, 32'h0000_0003);
    issue(cw(0, 6, 7, 8, 1, 1, 1), 1'b1);
    issue(cw(3, 1, 2, 4, 0, 1, 0), 1'b1);
    apb(1'b0, ci_decode_pkg::STAT_OFS, 0);
    check("stat", rd, 32'h0000_0003);
    apb(1'b0, ci_decode_pkg::OPS_OFS, 0);
    check("ops", rd, {17'h0_0000, 5'h02, 5'h04, 5'h01});
    apb(1'b0, ci_decode_pkg::SEL_OFS, 0);
    check("sel", rd, 32'h0000_0003);
    issue(cw(4, 6, 9, 2, 1, 0, 1), 1'b1);
    issue(cw(8'hff, 31, 0, 31, 0, 0, 0), 1'b1);
    issue(cw(5, 1, 1, 1, 1, 1, 1) ^ 32'h0000_0003, 1'b0);
    apb(1'b1, ci_decode_pkg::CTRL_OFS, 32'h0000_0500);
    apb(1'b1, ci_decode_pkg::INSTR_OFS, cw(5, 9, 10, 11, 1, 1, 1));
    @(posedge pclk);
    #1;
    check("sw", {unit_start, addr_a, addr_b, addr_c},
      {1'b1, 5'h0a, 5'h0b, 5'h09});
    apb(1'b0, ci_decode_pkg::INSTR_OFS, 0);
    check("instr", rd, cw(5, 9, 10, 11, 1, 1, 1));
    issue(cw(5, 2, 3, 4, 1, 1, 1), 1'b1);
    issue(cw(6, 2, 3, 4, 1, 1, 1), 1'b0);
    issue(cw(5, 2, 3, 4, 1, 0, 1), 1'b0);
    apb(1'b0, ci_decode_pkg::STAT_OFS, 0);
    check("refused", rd[2], 1'b1);
    give_verdict();
  end
endmodule : testbench
